// ==== design/sar_defines.svh ====
// timing, size and reset constants of the serial readout block
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

// ==========================================================
// result word
`define SAR_RESULT_BITS 15
`define SAR_RESULT_RST 15'h0000

// ==========================================================
// timing
`define SAR_CLK_PERIOD_NS 10
`define SAR_QUIET_NS 220
`define SAR_QUIET_CYC ((`SAR_QUIET_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)

// ==========================================================
// result buffer
`define SAR_FIFO_DEPTH 16

`endif

// ==== design/sar_pkg.sv ====
// types shared by the serial readout block
package sar_pkg;

    // ==========================================================
    // converter phase
    typedef enum logic [2:0] {
        SAR_ST_ACQ  = 3'h1,
        SAR_ST_CONV = 3'h2,
        SAR_ST_DONE = 3'h4
    } sar_state_t;

endpackage

// ==== design/sar_fifo.sv ====
// result buffer with registered read data and valid/ready on both sides
module sar_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // parameter check
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic wr_en;
    logic rd_en;

    assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
    assign wr_en = in_valid && in_ready;
    assign rd_en = (cnt_r != '0) && (!out_valid || out_ready);

    // ==========================================================
    // storage
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (wr_en) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (rd_en) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (wr_en && !rd_en) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (rd_en && !wr_en) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // ==========================================================
    // registered output stage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (rd_en) begin
            out_valid <= 1'b1;
            out_data <= mem_r[rd_ptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule

// ==== design/sar_adc_serial_readout.sv ====
// successive-approximation sequencer and serial result readout
// What this block does
// - while idle, keep the sampling switch closed on both differential inputs.
// - a falling convert strobe ends acquisition and starts conversion.
// - each serial clock pulse after the quiet time advances the weight array one approximation step.
// - after the last step a complete result word is ready for transfer, except when the previous word still waits for the buffer (overrun).
// - serial data changes on each serial clock falling edge after the quiet time, one bit each.
// - the result is a signed two's complement number.
// - twice the reference span is split into two to the fifteen codes.
// - bits shifted after a strobe belong to that strobe's own conversion.
// - the result leaves most significant bit first.
// - serial data is driven only while the strobe is low.
`include "sar_defines.svh"
module sar_adc_serial_readout #(
    parameter int BITS = `SAR_RESULT_BITS,
    parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // host link pins
    input wire logic convert_strobe_n,
    input wire logic sck,
    output logic sdo_o,
    output logic sdo_oe,
    // analog front end
    input wire logic comp_above,
    output logic sample_hold,
    output logic [BITS-1:0] capacitive_weight_array,
    // result stream
    output logic result_valid,
    input wire logic result_ready,
    output logic [BITS-1:0] result_data,
    output logic overrun
);
    localparam int CW = $clog2(BITS + 1);
    localparam int QW = $clog2(`SAR_QUIET_CYC + 1);
    localparam logic [QW-1:0] QUIET_CYC = QW'(`SAR_QUIET_CYC);
    localparam logic [CW-1:0] LAST_STEP = CW'(BITS - 1);

    // ==========================================================
    // parameter check
    generate
        if (BITS != `SAR_RESULT_BITS) begin : g_bad_bits
            $error("result width must be fifteen bits");
        end
    endgenerate

    // ==========================================================
    // helpers
    function automatic logic [BITS-1:0] sar_mid();
        logic [BITS-1:0] v;
        v = '0;
        v[BITS-1] = 1'b1;
        return v;
    endfunction

    function automatic logic [BITS-1:0] sar_step(input logic [BITS-1:0] code, input logic [CW-1:0] idx,
                                                 input logic keep);
        logic [BITS-1:0] v;
        v = code;
        v[idx] = keep;
        if (idx != '0) begin
            v[idx - 1'b1] = 1'b1;
        end
        return v;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [2:0] strobe_s;
    logic [2:0] sck_s;
    logic [1:0] comp_s;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            strobe_s <= 3'h7;
            sck_s <= 3'h0;
            comp_s <= 2'h0;
        end else begin
            strobe_s <= {strobe_s[1:0], convert_strobe_n};
            sck_s <= {sck_s[1:0], sck};
            comp_s <= {comp_s[0], comp_above};
        end
    end

    logic strobe_high;
    logic strobe_fall;
    logic sck_fall;
    assign strobe_high = strobe_s[1];
    assign strobe_fall = strobe_s[2] && !strobe_s[1];
    assign sck_fall = sck_s[2] && !sck_s[1];

    // ==========================================================
    // phase sequencing
    sar_pkg::sar_state_t state_r;
    sar_pkg::sar_state_t state_nxt;
    logic [CW-1:0] step_cnt_r;
    logic [QW-1:0] quiet_r;
    logic step;
    logic [CW-1:0] bit_idx;

    assign step = (state_r == sar_pkg::SAR_ST_CONV) && sck_fall && (quiet_r == '0);
    assign bit_idx = LAST_STEP - step_cnt_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sar_pkg::SAR_ST_ACQ: begin
                if (strobe_fall) begin
                    state_nxt = sar_pkg::SAR_ST_CONV;
                end
            end
            sar_pkg::SAR_ST_CONV: begin
                if (strobe_high) begin
                    state_nxt = sar_pkg::SAR_ST_ACQ;
                end else if (step && step_cnt_r == LAST_STEP) begin
                    state_nxt = sar_pkg::SAR_ST_DONE;
                end
            end
            sar_pkg::SAR_ST_DONE: begin
                if (strobe_high) begin
                    state_nxt = sar_pkg::SAR_ST_ACQ;
                end
            end
            default: begin
                state_nxt = sar_pkg::SAR_ST_ACQ;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= sar_pkg::SAR_ST_ACQ;
            sample_hold <= 1'b1;
        end else begin
            state_r <= state_nxt;
            sample_hold <= (state_nxt == sar_pkg::SAR_ST_ACQ);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            quiet_r <= '0;
        end else if (strobe_fall) begin
            quiet_r <= QUIET_CYC;
        end else if (quiet_r != '0) begin
            quiet_r <= quiet_r - 1'b1;
        end
    end

    // ==========================================================
    // approximation register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            step_cnt_r <= '0;
            capacitive_weight_array <= `SAR_RESULT_RST;
        end else if (strobe_fall) begin
            step_cnt_r <= '0;
            capacitive_weight_array <= sar_mid();
        end else if (step) begin
            step_cnt_r <= step_cnt_r + 1'b1;
            capacitive_weight_array <= sar_step(capacitive_weight_array, bit_idx, comp_s[1]);
        end
    end

    // ==========================================================
    // serial output
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sdo_o <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= !strobe_high;
            if (step) begin
                // offset binary to two's complement flips only the top bit
                sdo_o <= (bit_idx == LAST_STEP) ? !comp_s[1] : comp_s[1];
            end
        end
    end

    // ==========================================================
    // result hand-off into the buffer
    logic push_valid_r;
    logic [BITS-1:0] push_data_r;
    logic fifo_in_ready;
    logic [BITS-1:0] final_code;

    assign final_code = sar_step(capacitive_weight_array, '0, comp_s[1]);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            push_valid_r <= 1'b0;
            push_data_r <= `SAR_RESULT_RST;
        end else if (step && step_cnt_r == LAST_STEP && !(push_valid_r && !fifo_in_ready)) begin
            push_valid_r <= 1'b1;
            push_data_r <= {!final_code[BITS-1], final_code[BITS-2:0]};
        end else if (fifo_in_ready) begin
            push_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            overrun <= 1'b0;
        end else if (step && step_cnt_r == LAST_STEP && push_valid_r && !fifo_in_ready) begin
            overrun <= 1'b1;
        end else if (strobe_fall) begin
            overrun <= 1'b0;
        end
    end

    sar_fifo #(
        .WIDTH(BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(push_valid_r),
        .in_ready(fifo_in_ready),
        .in_data(push_data_r),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );

    // ==========================================================
    // checks
    a_idle_acquires: assert property (@(posedge sys_clk) disable iff (srst)
        strobe_high |=> sample_hold) else $error("sampling switch open while strobe high");

    a_fall_converts: assert property (@(posedge sys_clk) disable iff (srst)
        strobe_fall |=> (state_r == sar_pkg::SAR_ST_CONV) && !sample_hold)
        else $error("strobe fall did not start conversion");

    a_step_per_edge: assert property (@(posedge sys_clk) disable iff (srst)
        step && !strobe_high |=> step_cnt_r == $past(step_cnt_r) + 1'b1) else $error("step count did not advance");

    a_no_edge_still: assert property (@(posedge sys_clk) disable iff (srst)
        (state_r == sar_pkg::SAR_ST_CONV) && !step && !strobe_fall |=> $stable(capacitive_weight_array))
        else $error("weight array moved without serial edge");

    a_last_step_done: assert property (@(posedge sys_clk) disable iff (srst)
        step && step_cnt_r == LAST_STEP && !strobe_high |=> state_r == sar_pkg::SAR_ST_DONE)
        else $error("conversion did not end after last step");

    a_sdo_on_edge: assert property (@(posedge sys_clk) disable iff (srst)
        !$stable(sdo_o) |-> $past(step)) else $error("serial data changed without falling edge");

    a_msb_inverted: assert property (@(posedge sys_clk) disable iff (srst)
        step && step_cnt_r == '0 |=> sdo_o == !$past(comp_s[1])) else $error("first bit is not the sign bit");

    a_quiet_kept: assert property (@(posedge sys_clk) disable iff (srst)
        strobe_fall |=> !step [*8]) else $error("step taken inside quiet time");

    a_bus_release: assert property (@(posedge sys_clk) disable iff (srst)
        strobe_high |=> !sdo_oe) else $error("serial data driven while strobe high");

    a_bus_drive: assert property (@(posedge sys_clk) disable iff (srst)
        !strobe_high |=> sdo_oe) else $error("serial data not driven while strobe low");

    a_push_same_conv: assert property (@(posedge sys_clk) disable iff (srst)
        step && step_cnt_r == LAST_STEP && !push_valid_r |=> push_valid_r
            && push_data_r == {!capacitive_weight_array[BITS-1], capacitive_weight_array[BITS-2:0]})
        else $error("result word not taken from this conversion");

endmodule

// ==== testbench/sar_host_model.sv ====
// host model: convert strobe, serial clock, comparator answers, bit collection
module sar_host_model (
    // clock
    input wire logic sys_clk,
    // host link pins
    output logic convert_strobe_n,
    output logic sck,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // analog side
    output logic comp_above,
    // collected word
    output logic [14:0] rx_word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sdo_last;
    logic sdo_line;
    initial begin
        convert_strobe_n = 1'b1;
        sck = 1'b0;
        comp_above = 1'b0;
        rx_word = 15'h0000;
    end
    // a released line shows the inverse of its last driven level
    always @(posedge sys_clk) begin
        if (sdo_oe) begin
            sdo_last <= sdo_o;
        end
    end
    assign sdo_line = sdo_oe ? sdo_o : ~sdo_last;
    // ==========================================================
    // one frame; early adds a serial clock fall inside the quiet time
    task automatic frame(input logic [14:0] code, input int falls, input bit early);
        rx_word = 15'h0000;
        convert_strobe_n = 1'b0;
        if (early) begin
            repeat (4) @(negedge sys_clk);
            sck = 1'b1;
            repeat (4) @(negedge sys_clk);
            sck = 1'b0;
        end
        repeat (early ? 22 : 30) @(negedge sys_clk);
        for (int i = 0; i < falls; i++) begin
            comp_above = (i == 0) ? ~code[14] : code[14-i];
            sck = 1'b1;
            repeat (4) @(negedge sys_clk);
            sck = 1'b0;
            repeat (4) @(negedge sys_clk);
            // sampled on the following rise, kept unclamped
            rx_word = {rx_word[13:0], sdo_line};
        end
        convert_strobe_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench of the serial readout block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic convert_strobe_n, sck, sdo_o, sdo_oe, comp_above, sample_hold, result_valid, result_ready, overrun;
    logic [14:0] capacitive_weight_array, result_data, rx_word;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    sar_adc_serial_readout u_sar_adc_serial_readout (.sys_clk(sys_clk), .srst(srst),
        .convert_strobe_n(convert_strobe_n), .sck(sck), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .comp_above(comp_above), .sample_hold(sample_hold), .capacitive_weight_array(capacitive_weight_array),
        .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data), .overrun(overrun));
    sar_host_model u_host (.sys_clk(sys_clk), .convert_strobe_n(convert_strobe_n), .sck(sck), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .comp_above(comp_above), .rx_word(rx_word));
    // ==========================================================
    // compare and verdict
    task automatic check(input string name, input logic [14:0] seen, input logic [14:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic pop(input logic [14:0] exp);
        int n = 0;
        while (result_valid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check("result_valid", 15'(result_valid), 15'h0001);
        check("result_data", result_data, exp);
        result_ready = 1'b1;
        @(negedge sys_clk);
        result_ready = 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_codes();
        logic [14:0] codes [6] = '{15'h4000, 15'h3fff, 15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
        foreach (codes[i]) begin
            fork
                u_host.frame(codes[i], 15, 1'b0);
                begin
                    repeat (12) @(negedge sys_clk);
                    check("sample_hold", 15'(sample_hold), 15'h0000);
                    check("sdo_oe", 15'(sdo_oe), 15'h0001);
                    check("weight_start", capacitive_weight_array, 15'h4000);
                end
            join
            check("rx_word", rx_word, codes[i]);
            check("weight_end", capacitive_weight_array, codes[i] ^ 15'h4000);
            check("sdo_oe_idle", 15'(sdo_oe), 15'h0000);
            check("sample_hold_idle", 15'(sample_hold), 15'h0001);
            pop(codes[i]);
        end
    endtask
    task automatic t_abort();
        u_host.frame(15'h1234, 5, 1'b0);
        repeat (10) @(negedge sys_clk);
        check("abort_valid", 15'(result_valid), 15'h0000);
    endtask
    task automatic t_quiet();
        u_host.frame(15'h0a5c, 15, 1'b1);
        check("quiet_rx", rx_word, 15'h0a5c);
        pop(15'h0a5c);
    endtask
    task automatic t_fifo();
        int got = 0;
        for (int i = 0; i < 19; i++) begin
            u_host.frame(15'h0100 + i[14:0], 15, 1'b0);
        end
        check("overrun_set", 15'(overrun), 15'h0001);
        while (result_valid === 1'b1 && got < 20) begin
            pop(15'h0100 + got[14:0]);
            got++;
        end
        check("drained_count", 15'(got), 15'h0012);
        u_host.frame(15'h7001, 15, 1'b0);
        check("overrun_clear", 15'(overrun), 15'h0000);
        pop(15'h7001);
    endtask
    initial begin
        result_ready = 1'b0;
        repeat (3) @(negedge sys_clk);
        srst = 1'b0;
        check("reset_hold", 15'(sample_hold), 15'h0001);
        check("reset_oe", 15'(sdo_oe), 15'h0000);
        t_codes();
        t_abort();
        t_quiet();
        t_fifo();
        wrap_up();
    end
endmodule
